// *** verilog/adc_ctrl_regs.vh ***
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH
// byte addresses (printed offsets not all multiples of four: index * 4)
`define IDX_RESULT_HIGH 8'h3D
`define IDX_RESULT_LOW 8'h3E
`define IDX_STATUS_CTRL 8'h3C
`define IDX_CLOCK_CTRL 8'h3F
`define ADDR_RESULT_HIGH 10'h0F4
`define ADDR_RESULT_LOW 10'h0F8
`define ADDR_STATUS_CTRL 10'h0F0
`define ADDR_CLOCK_CTRL 10'h0FC
// status/control fields
`define SC_DONE_BIT 7
`define SC_IEN_BIT 6
`define SC_CONT_BIT 5
`define SC_CH_MSB 4
`define SC_CH_LSB 0
`define SC_RESET 8'h1F
// clock control fields
`define CC_DIV_MSB 7
`define CC_DIV_LSB 5
`define CC_SRC_BIT 4
`define CC_MODE_MSB 3
`define CC_MODE_LSB 2
`define CC_RESET 8'h04
// justification modes
`define MODE_TRUNC 2'h0
`define MODE_RIGHT 2'h1
`define MODE_LEFT 2'h2
`define MODE_SIGN 2'h3
// channel codes
`define CH_BANDGAP 5'h06
`define CH_REF_HIGH 5'h1D
`define CH_REF_LOW 5'h1E
`define CH_OFF 5'h1F
// converter timing: 16 converter clocks per conversion
`define CONV_CYCLES 5'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** verilog/conv_clock_div.v ***
`timescale 1ns/1ps
// converter clock tick generator: divide by 1, 2, 4, 8 or 16
module conv_clock_div (
  input wire clk,
  input wire sys_rst,
  input wire restart,
  input wire [2:0] divSel,
  output reg tick
);
  reg [3:0] cnt_q;
  reg [3:0] limit;
  always @* begin
    if (divSel[2]) begin
      limit = 4'hF;
    end else begin
      case (divSel[1:0])
        2'h0: limit = 4'h0;
        2'h1: limit = 4'h1;
        2'h2: limit = 4'h3;
        default: limit = 4'h7;
      endcase
    end
  end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_q <= 4'h0;
      tick <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 4'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      tick <= 1'b0;
    end
  end
endmodule

// *** verilog/adc_control_result_regs.v ***
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_control_result_regs (
  input wire clk,
  input wire sys_rst,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [9:0] convData,
  output reg [4:0] inputChannelSelect,
  output reg converterPowerOff,
  output reg [5:0] pinChannelEnable,
  output reg sampleStrobe,
  output reg convIrq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  ////////////////////////////////////////////////////////////////////
  // registers
  reg doneFlag_q;
  reg ien_q;
  reg cont_q;
  reg [4:0] chan_q;
  reg [7:0] clkCtrl_q;
  reg [7:0] resHigh_q;
  reg [7:0] resLow_q;
  reg frozen_q;
  reg state_q;
  reg [4:0] cycCnt_q;
  reg [9:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg awHave_q;
  reg wHave_q;
  wire [1:0] mode = clkCtrl_q[`CC_MODE_MSB:`CC_MODE_LSB];
  ////////////////////////////////////////////////////////////////////
  // write channel
  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire wrLane0 = doWrite && wStrb_q[0];
  wire wrStatus = wrLane0 && (awAddr_q == `ADDR_STATUS_CTRL);
  wire wrClock = wrLane0 && (awAddr_q == `ADDR_CLOCK_CTRL);
  reg wrMapped;
  always @* begin
    if (awAddr_q == `ADDR_STATUS_CTRL) begin
      wrMapped = 1'b1;
    end else if (awAddr_q == `ADDR_CLOCK_CTRL) begin
      wrMapped = 1'b1;
    end else if (awAddr_q == `ADDR_RESULT_HIGH || awAddr_q == `ADDR_RESULT_LOW) begin
      wrMapped = 1'b1;
    end else begin
      wrMapped = 1'b0;
    end
  end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awAddr_q <= 10'h000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !wHave_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // read channel
  wire rdTake = s_axi_arvalid && s_axi_arready;
  wire rdHigh = rdTake && (s_axi_araddr == `ADDR_RESULT_HIGH);
  wire rdLow = rdTake && (s_axi_araddr == `ADDR_RESULT_LOW);
  ////////////////////////////////////////////////////////////////////
  // read data select
  wire [7:0] statusByte = {doneFlag_q && !ien_q, ien_q, cont_q, chan_q};
  wire [7:0] clockByte = {clkCtrl_q[7:2], 2'h0};
  reg [7:0] rdByte;
  reg rdMapped;
  always @* begin
    rdByte = 8'h00;
    rdMapped = 1'b1;
    if (s_axi_araddr == `ADDR_STATUS_CTRL) begin
      rdByte = statusByte;
    end else if (s_axi_araddr == `ADDR_CLOCK_CTRL) begin
      rdByte = clockByte;
    end else if (s_axi_araddr == `ADDR_RESULT_HIGH) begin
      rdByte = resHigh_q;
    end else if (s_axi_araddr == `ADDR_RESULT_LOW) begin
      rdByte = resLow_q;
    end else begin
      rdMapped = 1'b0;
    end
  end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (rdTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rdata <= {24'h000000, rdByte};
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // converter clock and sequencing
  wire convTick;
  conv_clock_div clockDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .restart(wrStatus),
    .divSel(clkCtrl_q[`CC_DIV_MSB:`CC_DIV_LSB]),
    .tick(convTick)
  );
  wire newOff = wData_q[`SC_CH_MSB:`SC_CH_LSB] == `CH_OFF;
  wire convDone = (state_q == ST_CONV) && convTick && (cycCnt_q == `CONV_CYCLES - 5'h1);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cycCnt_q <= 5'h00;
    end else if (wrStatus) begin
      state_q <= newOff ? ST_IDLE : ST_CONV;
      cycCnt_q <= 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cycCnt_q <= 5'h00;
        end
        default: begin
          if (convDone) begin
            cycCnt_q <= 5'h00;
            state_q <= cont_q ? ST_CONV : ST_IDLE;
          end else if (convTick) begin
            cycCnt_q <= cycCnt_q + 5'h01;
          end
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // control registers and flags
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ien_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= `CH_OFF;
      clkCtrl_q <= `CC_RESET;
      doneFlag_q <= 1'b0;
      convIrq <= 1'b0;
    end else begin
      if (wrStatus) begin
        ien_q <= wData_q[`SC_IEN_BIT];
        cont_q <= wData_q[`SC_CONT_BIT];
        chan_q <= wData_q[`SC_CH_MSB:`SC_CH_LSB];
      end
      if (wrClock) begin
        clkCtrl_q <= {wData_q[7:2], 2'h0};
      end
      if (convDone && !ien_q) begin
        doneFlag_q <= 1'b1;
      end else if (wrStatus || wrClock || rdLow) begin
        doneFlag_q <= 1'b0;
      end
      if (convDone && ien_q) begin
        convIrq <= 1'b1;
      end else if (wrStatus || rdHigh || rdLow) begin
        convIrq <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // result justification
  reg [7:0] fmtHigh;
  reg [7:0] fmtLow;
  wire keepResult = mode == `MODE_TRUNC || !frozen_q;
  always @* begin
    fmtHigh = 8'h00;
    fmtLow = 8'h00;
    case (mode)
      `MODE_TRUNC: begin
        fmtLow = convData[9:2];
      end
      `MODE_RIGHT: begin
        fmtHigh = {6'h00, convData[9:8]};
        fmtLow = convData[7:0];
      end
      `MODE_LEFT: begin
        fmtHigh = convData[9:2];
        fmtLow = {convData[1:0], 6'h00};
      end
      default: begin
        fmtHigh = {~convData[9], convData[8:2]};
        fmtLow = {convData[1:0], 6'h00};
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // result formatting and interlock
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resHigh_q <= 8'h00;
      resLow_q <= 8'h00;
      frozen_q <= 1'b0;
    end else begin
      if (rdLow) begin
        frozen_q <= 1'b0;
      end else if (rdHigh && mode != `MODE_TRUNC) begin
        frozen_q <= 1'b1;
      end
      if (convDone && keepResult) begin
        resHigh_q <= fmtHigh;
        resLow_q <= fmtLow;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // analog mux controls
  integer i;
  reg [5:0] pinDecode;
  wire chanOff = chan_q == `CH_OFF;
  always @* begin
    pinDecode = 6'h00;
    for (i = 0; i < 6; i = i + 1) begin
      pinDecode[i] = chan_q == i[4:0];
    end
  end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inputChannelSelect <= `CH_OFF;
      converterPowerOff <= 1'b1;
      pinChannelEnable <= 6'h00;
      sampleStrobe <= 1'b0;
    end else begin
      inputChannelSelect <= chan_q;
      converterPowerOff <= chanOff;
      pinChannelEnable <= pinDecode;
      sampleStrobe <= convDone;
    end
  end
endmodule

// *** testbench/adc_control_result_regs_assertions.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_regs_checker (
  input wire clk,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [4:0] inputChannelSelect,
  input wire converterPowerOff,
  input wire [5:0] pinChannelEnable,
  input wire sampleStrobe,
  input wire convIrq
);
  wire busIdle = !s_axi_awvalid && !s_axi_wvalid && !s_axi_arvalid && !s_axi_bvalid
    && !s_axi_rvalid;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wrTaken; s_axi_awvalid && s_axi_awready; endsequence
  sequence rdTaken; s_axi_arvalid && s_axi_arready; endsequence
  //////////////////////////////////////////
  a_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read response not on time");
  a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  a_power_off: assert property (converterPowerOff == (inputChannelSelect == `CH_OFF))
    else $error("power off not tied to channel code");
  a_pin_enable: assert property (pinChannelEnable == ((inputChannelSelect < 5'h06) ?
    (6'h01 << inputChannelSelect) : 6'h00)) else $error("pin override wrong");
  a_strobe_gap: assert property (sampleStrobe |=> !sampleStrobe [*8])
    else $error("conversions too close");
  a_irq_hold: assert property (convIrq && busIdle && $past(busIdle) |=> convIrq)
    else $error("interrupt dropped without cause");
endmodule
bind adc_control_result_regs adc_regs_checker u_chk (.clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .inputChannelSelect, .converterPowerOff, .pinChannelEnable, .sampleStrobe,
  .convIrq);

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module testbench;
  localparam logic [9:0] SC = `ADDR_STATUS_CTRL;
  localparam logic [9:0] CC = `ADDR_CLOCK_CTRL;
  localparam logic [9:0] HI = `ADDR_RESULT_HIGH;
  localparam logic [9:0] LO = `ADDR_RESULT_LOW;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000, convData = 10'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0] inputChannelSelect;
  wire [5:0] pinChannelEnable;
  wire converterPowerOff, sampleStrobe, convIrq;
  int errCount = 0, nChecks = 0, cyc = 0;
  logic [1:0] bResp = 2'h0;
  always #12.5 clk = ~clk;
  adc_control_result_regs dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1), .convData,
    .inputChannelSelect, .converterPowerOff, .pinChannelEnable, .sampleStrobe, .convIrq);
  //////////////////////////////////////////
  task wrapUp;
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      wrapUp;
    end
  end
  task chk(input logic [33:0] g, input logic [33:0] e);
    nChecks++;
    if (g !== e) begin
      errCount++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    bResp = s_axi_bresp;
  endtask
  task rd(input logic [9:0] a, output logic [33:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = {s_axi_rresp, s_axi_rdata};
  endtask
  task rdc(input logic [9:0] a, input logic [7:0] e);
    logic [33:0] v;
    rd(a, v);
    chk(v, {`RESP_OKAY, 24'h000000, e});
  endtask
  task ws;
    while (sampleStrobe !== 1'h1) @(posedge clk);
    @(posedge clk);
  endtask
  task convTime(input int ratio);
    int n;
    wr(SC, 8'h00);
    n = 0;
    while (sampleStrobe !== 1'h1) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 16 * ratio && n <= 17 * ratio, 1'h1);
  endtask
  //////////////////////////////////////////
  task tReset;
    logic [33:0] v;
    wr(HI, 8'hFF);
    chk(bResp, `RESP_OKAY);
    wr(LO, 8'hFF);
    chk(bResp, `RESP_OKAY);
    wr(10'h000, 8'h00);
    chk(bResp, `RESP_SLVERR);
    rdc(SC, `SC_RESET);
    rdc(CC, `CC_RESET);
    rdc(HI, 8'h00);
    rdc(LO, 8'h00);
    rd(10'h000, v);
    chk(v, {`RESP_SLVERR, 32'h00000000});
  endtask
  task tModes;
    logic [7:0] hi [4] = '{8'h00, 8'h02, 8'hA9, 8'h29};
    logic [7:0] lo [4] = '{8'hA9, 8'hA5, 8'h40, 8'h40};
    convData <= 10'h2A5;
    wr(SC, 8'h00);
    ws;
    for (int m = 0; m < 4; m++) begin
      wr(CC, {4'h0, m[1:0], 2'h0});
      wr(SC, 8'h00);
      ws;
      rdc(SC, 8'h80);
      rdc(HI, hi[m]);
      rdc(LO, lo[m]);
      repeat (40) @(posedge clk);
      rdc(SC, 8'h00);
    end
    wr(SC, 8'h00);
    ws;
    wr(CC, 8'h04);
    rdc(SC, 8'h00);
  endtask
  task tIrq;
    convData <= 10'h3FF;
    wr(SC, 8'h40);
    ws;
    rdc(SC, 8'h40);
    chk(convIrq, 1'h1);
    rdc(HI, 8'h03);
    repeat (2) @(posedge clk);
    chk(convIrq, 1'h0);
    rdc(LO, 8'hFF);
    wr(SC, 8'h40);
    ws;
    wr(SC, 8'h40);
    @(posedge clk);
    chk(convIrq, 1'h0);
  endtask
  task tInterlock;
    convData <= 10'h155;
    wr(SC, 8'h20);
    ws;
    rdc(HI, 8'h01);
    wr(LO, 8'h00);
    chk(bResp, `RESP_OKAY);
    convData <= 10'h2AA;
    repeat (40) @(posedge clk);
    rdc(LO, 8'h55);
    repeat (40) @(posedge clk);
    rdc(HI, 8'h02);
    rdc(LO, 8'hAA);
    wr(SC, 8'h1F);
  endtask
  task tChannels;
    for (int c = 0; c < 32; c++) begin
      wr(SC, c[7:0]);
      rdc(SC, c[7:0]);
      chk(inputChannelSelect, c[4:0]);
      chk(pinChannelEnable, (c < 6) ? (6'h01 << c) : 6'h00);
    end
    chk(converterPowerOff, 1'h1);
  endtask
  task tAbort;
    wr(SC, 8'h00);
    repeat (5) @(posedge clk);
    convTime(1);
  endtask
  task tDivider;
    wr(CC, 8'h24);
    convTime(2);
    wr(CC, 8'h64);
    convTime(8);
    wr(CC, 8'hE4);
    convTime(16);
    wr(CC, 8'h04);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    tReset;
    tModes;
    tIrq;
    tInterlock;
    tChannels;
    tAbort;
    tDivider;
    wrapUp;
  end
endmodule
